/* verilog/rcb_top.sv */
`timescale 1ns/10ps
`include "rcb_defs.svh"

// Word buffer between the input pipeline and the output register.
module rcb_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_nrst,
	// Fill side.
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	// Drain side.
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0] cnt_ff;
	wire push = i_in_valid & o_in_ready;
	wire pop = o_out_valid & i_out_ready;
	wire [AW:0] depth_c = (AW+1)'(DEPTH);
	wire [AW-1:0] last_c = AW'(DEPTH - 1);

	// Full and empty come straight from the occupancy count. A push into a
	// full buffer is refused here, so the caller sees the word as dropped.
	// Full and empty come straight from the occupancy count.
	assign o_in_ready = (cnt_ff != depth_c);
	assign o_out_valid = (cnt_ff != '0);
	assign o_out_data = mem[rd_ff];

	// Storage has no reset; only the pointers and the count need a defined start.
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ff] <= i_in_data;
		end
	end

	// Pointers wrap at the depth, so the depth need not be a power of two.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wr_ff <= (wr_ff == last_c) ? '0 : wr_ff + 1'b1;
			end
			if (pop) begin
				rd_ff <= (rd_ff == last_c) ? '0 : rd_ff + 1'b1;
			end
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// Registered command buffer with parity check.
module rcb_top
	import rcb_pkg::*;
#(
	parameter int DATA_W = `RCB_DATA_W,
	parameter int FIFO_DEPTH = `RCB_FIFO_DEPTH,
	parameter logic [`RCB_DATA_W-1:0] MASK_A = `RCB_MASK_A,
	parameter logic [`RCB_DATA_W-1:0] MASK_B = `RCB_MASK_B
) (
	// Clock and reset.
	input wire logic I_MCLK,
	input wire logic I_NRST,
	// Static configuration and gating.
	input wire logic I_CFG_SEL,
	input wire logic I_CS_GATE_EN,
	// Command word from the controller.
	input wire logic [1:0] I_CS_N,
	input wire logic [1:0] I_CKE,
	input wire logic [1:0] I_ODT,
	input wire logic I_PARITY,
	input wire logic [`RCB_DATA_W-1:0] I_DATA,
	// Output stall from downstream.
	input wire logic I_OUT_STALL,
	// Redriven word.
	output logic [`RCB_DATA_W-1:0] O_Q,
	output logic [1:0] O_CS_N,
	output logic [1:0] O_CKE,
	output logic [1:0] O_ODT,
	// Open-drain parity error pin and status.
	output logic O_PARITY_ERR_N_O,
	output logic O_PARITY_ERR_N_OE,
	output logic O_LOW_POWER,
	output logic O_IN_READY
);
	rcb_pins_t pins_c;
	rcb_pins_t s1_ff;
	rcb_pins_t s2_ff;
	rcb_word_t word_c;
	rcb_word_t head_c;
	logic [1:0] rx_vld_ff;
	logic prev_sum_ff;
	logic prev_chk_ff;
	logic [1:0] hold_ff;
	logic [DATA_W-1:0] q_ff;
	logic [1:0] cs_ff;
	logic [1:0] cke_ff;
	logic [1:0] odt_ff;
	logic err_ff;
	logic lpm_ff;
	logic rdy_ff;
	logic [1:0] nxt_hold;
	logic nxt_err;
	logic head_vld;
	logic fifo_rdy;
	logic [RCB_WORD_W-1:0] head_bits;

	// Every command and configuration pin passes two flops before use; all of them are sampled on the
	// same rising edge, so one word and its selects stay aligned.
	assign pins_c = '{cfg: I_CFG_SEL, gate_en: I_CS_GATE_EN, cs_n: I_CS_N, cke: I_CKE,
		odt: I_ODT, par: I_PARITY, d: I_DATA};

	// Receivers come up empty: reset clears both stages and the valid chain.
	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			s1_ff <= '0;
			s2_ff <= '0;
			rx_vld_ff <= 2'h0;
		end else begin
			s1_ff <= pins_c;
			s2_ff <= s1_ff;
			rx_vld_ff <= {rx_vld_ff[0], 1'b1};
		end
	end

	// Parity pairing: the word seen last cycle is checked against the
	// parity bit that arrives now, so the flag rides with the next word.
	wire [DATA_W-1:0] chk_mask = s2_ff.cfg ? MASK_B : MASK_A;
	wire cur_sum = ^(s2_ff.d & chk_mask);
	wire cur_chk = ~&s2_ff.cs_n;
	wire par_bad = prev_chk_ff & (prev_sum_ff ^ s2_ff.par);
	assign word_c = '{gate_en: s2_ff.gate_en, cs_n: s2_ff.cs_n, cke: s2_ff.cke,
		odt: s2_ff.odt, par_err: par_bad, d: s2_ff.d};

	// Only words with a select low are checked; others raise no flag.
	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			prev_sum_ff <= 1'b0;
			prev_chk_ff <= 1'b0;
		end else if (rx_vld_ff[1]) begin
			prev_sum_ff <= cur_sum;
			prev_chk_ff <= cur_chk;
		end
	end

	// The buffer absorbs a downstream stall of up to its depth; past that
	// the pins cannot be held, so the ready flag tells the controller.
	rcb_fifo #(
		.WIDTH(RCB_WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk(I_MCLK),
		.i_nrst(I_NRST),
		.i_in_valid(rx_vld_ff[1]),
		.i_in_data(word_c),
		.o_in_ready(fifo_rdy),
		.o_out_valid(head_vld),
		.o_out_data(head_bits),
		.i_out_ready(~I_OUT_STALL)
	);

	// The buffer head is split into the gating terms for the output stage.
	assign head_c = rcb_word_t'(head_bits);
	wire pop = head_vld & ~I_OUT_STALL;
	wire any_cs = ~&head_c.cs_n;
	wire capture = ~head_c.gate_en | any_cs;
	wire low_power_state = head_c.gate_en & ~any_cs;

	// Error latch: a flag reloads the hold count; low power keeps it loaded
	// so the error survives standby and then runs two more words.
	// A flag that rides in the first standby word still sets the latch.
	always_comb begin
		nxt_err = err_ff;
		nxt_hold = hold_ff;
		if (head_c.par_err) begin
			nxt_err = 1'b1;
			nxt_hold = `RCB_ERR_HOLD;
		end else if (err_ff & low_power_state) begin
			nxt_hold = `RCB_ERR_HOLD;
		end else if (err_ff) begin
			nxt_hold = hold_ff - 2'h1;
			nxt_err = (hold_ff != 2'h1);
		end
	end

	// Output register: selects, clock enables and termination follow every
	// word; the data field only when the gating allows a capture.
	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			q_ff <= '0;
			cs_ff <= 2'h0;
			cke_ff <= 2'h0;
			odt_ff <= 2'h0;
			lpm_ff <= 1'b0;
		end else if (pop) begin
			if (capture) begin
				q_ff <= head_c.d;
			end
			cs_ff <= head_c.cs_n;
			cke_ff <= head_c.cke;
			odt_ff <= head_c.odt;
			lpm_ff <= low_power_state;
		end
	end

	// Error state advances per drained word so it stays tied to the data.
	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			err_ff <= 1'b0;
			hold_ff <= 2'h0;
			rdy_ff <= 1'b0;
		end else begin
			if (pop) begin
				err_ff <= nxt_err;
				hold_ff <= nxt_hold;
			end
			rdy_ff <= fifo_rdy;
		end
	end

	// Outputs are flop copies; the open-drain value itself is fixed low.
	assign O_Q = q_ff;
	assign O_CS_N = cs_ff;
	assign O_CKE = cke_ff;
	assign O_ODT = odt_ff;
	assign O_PARITY_ERR_N_O = 1'b0;
	assign O_PARITY_ERR_N_OE = err_ff;
	assign O_LOW_POWER = lpm_ff;
	assign O_IN_READY = rdy_ff;

	// All checks run on the one clock and rest while reset is low, except
	// the reset checks, which watch the cleared state itself.
	default clocking cb @(posedge I_MCLK);
	endclocking
	default disable iff (!I_NRST);

	a_cs_capture: assert property (
		pop && head_c.gate_en && any_cs |=> O_Q == $past(head_c.d))
		else $error("data not captured with select low");
	a_gate_low_capture: assert property (
		pop && !head_c.gate_en |=> O_Q == $past(head_c.d))
		else $error("data not captured with gate low");
	a_data_disabled: assert property (
		pop && low_power_state |=> $stable(O_Q) && O_LOW_POWER)
		else $error("data changed while disabled");
	a_stall_holds_q: assert property (
		!pop |=> $stable(O_Q) && $stable(O_CS_N))
		else $error("outputs moved without a word");
	a_side_bits_fwd: assert property (
		pop |=> O_CKE == $past(head_c.cke) && O_ODT == $past(head_c.odt))
		else $error("enable or termination not forwarded");
	a_select_fwd: assert property (
		pop |=> O_CS_N == $past(head_c.cs_n))
		else $error("select outputs not updated");
	a_err_follows: assert property (
		pop && head_c.par_err |=> O_PARITY_ERR_N_OE && !O_PARITY_ERR_N_O)
		else $error("error not driven after flagged word");
	a_err_two_words: assert property (
		O_PARITY_ERR_N_OE && pop && hold_ff == 2'h2 |=> O_PARITY_ERR_N_OE)
		else $error("error released too early");
	a_err_release: assert property (
		O_PARITY_ERR_N_OE && pop && hold_ff == 2'h1 && !head_c.par_err && !low_power_state |=>
			!O_PARITY_ERR_N_OE)
		else $error("error held too long");
	a_err_reload: assert property (
		pop && head_c.par_err |=> O_PARITY_ERR_N_OE && hold_ff == 2'h2)
		else $error("new error did not reload the hold");
	a_lpm_flag_kept: assert property (
		pop && head_c.par_err && low_power_state |=> O_PARITY_ERR_N_OE && O_LOW_POWER)
		else $error("error lost on entry to low power");
	a_lpm_out: assert property (
		pop |=> O_LOW_POWER == $past(low_power_state))
		else $error("low power flag not updated");
	a_pin_align: assert property (
		rx_vld_ff[1] |-> s2_ff == $past(pins_c, 2))
		else $error("synchronised word misaligned");
	a_lpm_err_kept: assert property (
		O_PARITY_ERR_N_OE && pop && low_power_state |=> O_PARITY_ERR_N_OE && hold_ff == 2'h2)
		else $error("error dropped in low power");
	a_pair_parity: assert property (
		rx_vld_ff[1] && cur_chk ##1 rx_vld_ff[1] |->
			word_c.par_err == ($past(cur_sum) ^ s2_ff.par))
		else $error("parity pairing wrong");
	a_reset_state: assert property (
		@(posedge I_MCLK) disable iff (1'b0)
		!I_NRST |-> O_Q == '0 && !O_PARITY_ERR_N_OE && s2_ff == '0)
		else $error("reset state wrong");
	a_reset_clears: assert property (
		@(posedge I_MCLK) disable iff (1'b0)
		!I_NRST |-> rx_vld_ff == 2'h0 && !prev_chk_ff && !O_LOW_POWER)
		else $error("receivers not cleared in reset");
endmodule

/* verilog/rcb_defs.svh */
`ifndef RCB_DEFS_SVH
`define RCB_DEFS_SVH

// Widths and depths.
`define RCB_DATA_W 28
`define RCB_FIFO_DEPTH 8
// Drained words the error output stays low after it is flagged.
`define RCB_ERR_HOLD 2'h2
// Checked data bits for configuration A (select low) and B (select high).
`define RCB_MASK_A 28'hFFFFFFF
`define RCB_MASK_B 28'h0FFFFFF
`endif

/* verilog/rcb_pkg.sv */
`include "rcb_defs.svh"
package rcb_pkg;
	// Raw pin sample, carried through the input synchroniser.
	typedef struct packed {
		logic cfg;
		logic gate_en;
		logic [1:0] cs_n;
		logic [1:0] cke;
		logic [1:0] odt;
		logic par;
		logic [`RCB_DATA_W-1:0] d;
	} rcb_pins_t;
	// One command word as it waits in the buffer.
	typedef struct packed {
		logic gate_en;
		logic [1:0] cs_n;
		logic [1:0] cke;
		logic [1:0] odt;
		logic par_err;
		logic [`RCB_DATA_W-1:0] d;
	} rcb_word_t;
	localparam int RCB_WORD_W = $bits(rcb_word_t);
endpackage

/* tb/rcb_ctrl_model.sv */
`timescale 1ns/10ps
`include "rcb_defs.svh"

// Controller model: drives each word at the falling edge and its parity one cycle later.
module rcb_ctrl_model (
	// Clock and parity control.
	input wire logic i_clk,
	input wire logic i_cfg,
	input wire logic i_bad,
	// Word to send.
	input wire logic [1:0] i_cs_n,
	input wire logic [1:0] i_cke,
	input wire logic [1:0] i_odt,
	input wire logic [`RCB_DATA_W-1:0] i_d,
	// Pins toward the buffer.
	output logic [1:0] o_cs_n,
	output logic [1:0] o_cke,
	output logic [1:0] o_odt,
	output logic [`RCB_DATA_W-1:0] o_d,
	output logic o_par
);
	logic [`RCB_DATA_W-1:0] mask;
	logic chk_ff;
	logic bad_ff;
	assign mask = i_cfg ? `RCB_MASK_B : `RCB_MASK_A;
	// Pins start idle with no select low.
	initial begin
		o_cs_n = 2'h3;
		o_cke = 2'h0;
		o_odt = 2'h0;
		o_d = '0;
		o_par = 1'h0;
		chk_ff = 1'h0;
		bad_ff = 1'h0;
	end
	// Unchecked parity slots toggle, so a stale value never looks valid.
	always @(negedge i_clk) begin
		o_par <= chk_ff ? (^(o_d & mask)) ^ bad_ff : ~o_par;
		chk_ff <= ~&i_cs_n;
		bad_ff <= i_bad;
		o_cs_n <= i_cs_n;
		o_cke <= i_cke;
		o_odt <= i_odt;
		o_d <= i_d;
	end
endmodule

/* tb/tb_rcb_top.sv */
`timescale 1ns/10ps
`include "rcb_defs.svh"

module tb_rcb_top;
	logic mclk = 1'h0;
	logic nrst, cfg, p_cfg, gate, stall, bad;
	logic [1:0] cs_n, cke, odt, m_cs_n, m_cke, m_odt, q_cs_n, q_cke, q_odt;
	logic [27:0] d, m_d, q;
	logic m_par, err_o, err_oe, low_power_state, rdy;
	int num_errors, comparisons;

	// A 100 ns period.
	always #50 mclk = ~mclk;

	rcb_ctrl_model rcb_ctrl_model_i (.i_clk(mclk), .i_cfg(p_cfg), .i_bad(bad),
		.i_cs_n(cs_n), .i_cke(cke), .i_odt(odt), .i_d(d), .o_cs_n(m_cs_n),
		.o_cke(m_cke), .o_odt(m_odt), .o_d(m_d), .o_par(m_par));
	rcb_top rcb_top_i (.I_MCLK(mclk), .I_NRST(nrst), .I_CFG_SEL(cfg),
		.I_CS_GATE_EN(gate), .I_CS_N(m_cs_n), .I_CKE(m_cke), .I_ODT(m_odt),
		.I_PARITY(m_par), .I_DATA(m_d), .I_OUT_STALL(stall), .O_Q(q),
		.O_CS_N(q_cs_n), .O_CKE(q_cke), .O_ODT(q_odt), .O_PARITY_ERR_N_O(err_o),
		.O_PARITY_ERR_N_OE(err_oe), .O_LOW_POWER(low_power_state), .O_IN_READY(rdy));

	task chk(input string what, input logic [27:0] exp, input logic [27:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			num_errors++;
		end
	endtask

	// Words change after a rising edge; the model puts them on the pins at the falling one.
	task put(input logic [1:0] c, input logic [27:0] v, input logic b);
		@(posedge mclk);
		cs_n = c;
		d = v;
		bad = b;
		cke = v[1:0];
		odt = v[3:2];
	endtask

	task settle;
		repeat (6) @(negedge mclk);
	endtask

	task t_gating;
		put(2'h3, 28'h1234567, 1'h0);
		settle;
		chk("q", 28'h1234567, q);
		@(negedge mclk);
		gate = 1'h1;
		put(2'h3, 28'hABCDEF6, 1'h0);
		settle;
		chk("q held", 28'h1234567, q);
		chk("cke", 28'h2, q_cke);
		chk("odt", 28'h1, q_odt);
		chk("cs", 28'h3, q_cs_n);
		chk("lpm", 28'h1, low_power_state);
		for (int i = 1; i < 3; i++) begin
			put(2'(i), 28'h5A5A5A0 + 28'(i), 1'h0);
			settle;
			chk("q sel", 28'h5A5A5A0 + 28'(i), q);
			chk("cs sel", 28'(i), q_cs_n);
		end
	endtask

	// A flagged word must pull the error pin for two or three drained words.
	task t_parity(input logic c, input logic pc, input logic [27:0] v, input logic b,
		input logic exp);
		int n;
		@(negedge mclk);
		cfg = c;
		p_cfg = pc;
		gate = 1'h0;
		put(2'h3, 28'h0, 1'h0);
		repeat (4) @(posedge mclk);
		put(2'h0, v, b);
		put(2'h3, 28'h0, 1'h0);
		n = 0;
		repeat (12) begin
			@(negedge mclk);
			n += (err_oe === 1'h1);
		end
		chk("err flagged", 28'(exp), 28'(n != 0));
		chk("err span", 28'h1, 28'(n == 0 || n == 2 || n == 3));
	endtask

	// An error flagged just before standby must last through it.
	task t_lpm;
		@(negedge mclk);
		gate = 1'h1;
		put(2'h0, 28'h0000007, 1'h1);
		put(2'h3, 28'h0, 1'h0);
		repeat (10) @(negedge mclk);
		chk("err in lpm", 28'h1, 28'(err_oe));
		chk("err pin", 28'h0, 28'(err_o));
		put(2'h0, 28'h0, 1'h0);
		repeat (8) @(negedge mclk);
		chk("err after lpm", 28'h0, 28'(err_oe));
		gate = 1'h0;
	endtask

	task t_stall;
		int k;
		@(negedge mclk);
		stall = 1'h1;
		put(2'h0, 28'h1111111, 1'h0);
		k = 0;
		while (rdy === 1'h1 && k < 30) begin
			@(negedge mclk);
			k++;
		end
		chk("full", 28'h0, 28'(rdy));
		stall = 1'h0;
		repeat (14) @(negedge mclk);
		chk("ready", 28'h1, 28'(rdy));
		chk("q drained", 28'h1111111, q);
	endtask

	task t_reset;
		put(2'h3, 28'h0, 1'h0);
		settle;
		nrst = 1'h0;
		#10;
		chk("q rst", 28'h0, q);
		chk("cs rst", 28'h0, q_cs_n);
		chk("err rst", 28'h0, 28'(err_oe));
		@(negedge mclk);
		nrst = 1'h1;
		settle;
		chk("q after", 28'h0, q);
	endtask

	task wrap_up;
		$display("Errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// The whole run needs about 200 cycles.
	initial begin
		repeat (2000) @(posedge mclk);
		num_errors++;
		wrap_up;
	end

	initial begin
		{nrst, cfg, p_cfg, gate, stall, bad} = 6'h20;
		{cs_n, cke, odt, d} = {2'h3, 4'h0, 28'h0};
		num_errors = 0;
		comparisons = 0;
		// Reset starts high so its fall is an edge that the flops see.
		#10;
		nrst = 1'h0;
		repeat (2) @(negedge mclk);
		nrst = 1'h1;
		t_gating;
		t_parity(1'h0, 1'h0, 28'h0000007, 1'h1, 1'h1);
		t_parity(1'h0, 1'h0, 28'h0000006, 1'h1, 1'h1);
		t_parity(1'h0, 1'h0, 28'h0000007, 1'h0, 1'h0);
		t_parity(1'h1, 1'h0, 28'h8000000, 1'h0, 1'h1);
		t_parity(1'h1, 1'h1, 28'h8000000, 1'h0, 1'h0);
		t_lpm;
		t_stall;
		t_reset;
		wrap_up;
	end
endmodule
